//--- hdl/pid_precharge_pkg.sv
// Types shared by the pre-charge sequencer
// Assumes the register header is compiled alongside
package pid_precharge_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_OTHER, S_RAMP, S_PCH, S_PID, S_SLEEP, S_DECEL, S_FAULT
    } state_t;
endpackage

//--- hdl/pid_precharge_regs.svh
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by bare name from the sequencer and its testbench
`ifndef PID_PRECHARGE_REGS_SVH
`define PID_PRECHARGE_REGS_SVH
`define PCH_DISABLE 16'h270F
`define A_END_LEVEL 4'h0
`define A_END_TIME 4'h1
`define A_UPPER_LEVEL 4'h2
`define A_TIME_LIMIT 4'h3
`define A_FAULT_SEL 4'h4
`define A_RETRY_SEL 4'h5
`define A_SECOND_ACT 4'h6
`define A_CTRL 4'h7
`define A_STATUS 4'h8
`define A_ELAPSED 4'h9
`define CTRL_ENABLE 0
`define CTRL_END_ASSIGNED 1
`define CTRL_RESET 16'h0000
`define FAULT_SEL_IMMEDIATE 16'h0000
`define RETRY_SEL_A 16'h0000
`define RETRY_SEL_B 16'h0004
`define ACT_DEV_REV_A 16'h000A
`define ACT_DEV_REV_B 16'h006E
`define ACT_DEV_FWD_A 16'h000B
`define ACT_DEV_FWD_B 16'h006F
`define ACT_MSP_REV_A 16'h0014
`define ACT_MSP_REV_B 16'h0078
`define ACT_MSP_FWD_A 16'h0015
`define ACT_MSP_FWD_B 16'h0079
`define TICK_MS 100
`define CLK_KHZ 50000
`endif

//--- hdl/pid_precharge_sequencer.sv
// Pre-charge sequencer ahead of PID regulation, with limit protection
// and second parameter set selection.
// Assumes all inputs synchronous to core_clk; registers on a plain port.
//
// Behaviour
// - End pre-charge when measured amount reaches end level, unless disabled.
// - End pre-charge when elapsed time reaches end time, unless disabled.
// - End pre-charge on rising edge of the assigned end-command input.
// - Start with end-command asserted skips pre-charge, PID runs at once.
// - End-command held skips pre-charge after sleep; controller re-arms.
// - Output shutoff cancellation runs pre-charge again when enabled.
// - Shutoff cancelled with end-command asserted goes straight to PID.
// - From higher-priority source, ramp to switchover, then pre-charge.
// - Limit violation sets method's fault flag, shuts output, raises fault.
// - Fault selection picks immediate shutoff or decelerate then fault.
// - Limit protection acts whether or not ending conditions exist.
// - Limits accepted only above end time and end level.
// - Fault flags stay latched; decelerate option raises fault after stop.
// - Fault flags clear only on reset or retry.
// - Fault when elapsed time reaches time limit during pre-charge.
// - Fault when measured amount exceeds upper level during pre-charge.
// - Retry only when retry selection is 0 or 4.
// - Second-function input with selection not 9999 uses second set.
// - Selection 9999 keeps normal set despite second-function input.
// - Leaving second set preloads integral from frequency and P term.
// - Decode second action codes into direction and input kind.
// - First satisfied ending condition ends pre-charge.
// - No sleep until pre-charge has completed.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pid_precharge_regs.svh"
module pid_precharge_sequencer #(
    parameter int DATA_W = 16,
    parameter int TICK_CYCLES = `CLK_KHZ * `TICK_MS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    input wire logic startCmd,
    input wire logic pidSelect,
    input wire logic higherPrioSrc,
    input wire logic atSwitchFreq,
    input wire logic shutoffIn,
    input wire logic sleepReq,
    input wire logic precharge_end_cmd,
    input wire logic second_function_select,
    input wire logic [DATA_W-1:0] measured,
    input wire logic [1:0] controlMethod,
    input wire logic motorStopped,
    input wire logic retryReq,
    input wire logic [DATA_W-1:0] outFreq,
    input wire logic [DATA_W-1:0] pTerm,
    output logic precharging_flag,
    output logic pidRun,
    output logic rampCmd,
    output logic decelCmd,
    output logic outputOff,
    output logic sleepActive,
    output logic [3:0] precharge_fault_flags,
    output logic precharge_fault,
    output logic useSecondSet,
    output logic reverseAction,
    output logic deviationInput,
    output logic integralPreload,
    output logic [DATA_W-1:0] integralValue
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    logic [DATA_W-1:0] precharge_end_level;
    logic [DATA_W-1:0] precharge_end_time;
    logic [DATA_W-1:0] upper_detect_level;
    logic [DATA_W-1:0] precharge_time_limit;
    logic [DATA_W-1:0] fault_behaviour_select;
    logic [DATA_W-1:0] retry_select;
    logic [DATA_W-1:0] second_action_select;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] elapsed;
    logic [TICK_W-1:0] tickCnt;
    logic endCmdPrev;
    logic secondPrev;
    pid_precharge_pkg::state_t state;
    pid_precharge_pkg::state_t next_state;
    pid_precharge_pkg::state_t entryState;
    logic pchEnabled;
    logic endCmdActive;
    logic endReached;
    logic limitHit;
    logic retryOk;
    logic second_next;

    function automatic logic active(input logic [DATA_W-1:0] v);
        active = v != DATA_W'(`PCH_DISABLE);
    endfunction

    assign pchEnabled = ctrl[`CTRL_ENABLE];
    assign endCmdActive = ctrl[`CTRL_END_ASSIGNED] & precharge_end_cmd;
    assign retryOk = retry_select == DATA_W'(`RETRY_SEL_A) ||
        retry_select == DATA_W'(`RETRY_SEL_B);

    // Held end command skips pre-charge on every entry
    always_comb begin
        if (!pchEnabled || endCmdActive) begin
            entryState = pid_precharge_pkg::S_PID;
        end else begin
            entryState = pid_precharge_pkg::S_PCH;
        end
    end

    // Any ending condition suffices; the first one to hold wins
    always_comb begin
        endReached = 1'b0;
        if (active(precharge_end_level) &&
            measured >= precharge_end_level) begin
            endReached = 1'b1;
        end
        if (active(precharge_end_time) &&
            elapsed >= precharge_end_time) begin
            endReached = 1'b1;
        end
        if (endCmdActive && !endCmdPrev) begin
            endReached = 1'b1;
        end
    end

    // Limits are checked independently of the ending conditions
    always_comb begin
        limitHit = 1'b0;
        if (active(precharge_time_limit) &&
            elapsed >= precharge_time_limit) begin
            limitHit = 1'b1;
        end
        if (active(upper_detect_level) &&
            measured > upper_detect_level) begin
            limitHit = 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            pid_precharge_pkg::S_IDLE: begin
                if (startCmd && !shutoffIn) begin
                    next_state = pidSelect ? entryState :
                        pid_precharge_pkg::S_OTHER;
                end
            end
            pid_precharge_pkg::S_OTHER: begin
                if (pidSelect && !higherPrioSrc) begin
                    next_state = pid_precharge_pkg::S_RAMP;
                end
            end
            pid_precharge_pkg::S_RAMP: begin
                if (atSwitchFreq) begin
                    next_state = entryState;
                end
            end
            pid_precharge_pkg::S_PCH: begin
                if (limitHit) begin
                    if (fault_behaviour_select ==
                        DATA_W'(`FAULT_SEL_IMMEDIATE)) begin
                        next_state = pid_precharge_pkg::S_FAULT;
                    end else begin
                        next_state = pid_precharge_pkg::S_DECEL;
                    end
                end else if (endReached) begin
                    next_state = pid_precharge_pkg::S_PID;
                end
            end
            pid_precharge_pkg::S_PID: begin
                if (sleepReq) begin
                    next_state = pid_precharge_pkg::S_SLEEP;
                end
            end
            pid_precharge_pkg::S_SLEEP: begin
                if (!sleepReq) begin
                    next_state = entryState;
                end
            end
            pid_precharge_pkg::S_DECEL: begin
                if (motorStopped) begin
                    next_state = pid_precharge_pkg::S_FAULT;
                end
            end
            pid_precharge_pkg::S_FAULT: begin
                if (retryReq && retryOk) begin
                    next_state = pid_precharge_pkg::S_IDLE;
                end
            end
            default: begin
                next_state = pid_precharge_pkg::S_IDLE;
            end
        endcase
        if (state != pid_precharge_pkg::S_FAULT &&
            state != pid_precharge_pkg::S_DECEL &&
            !(state == pid_precharge_pkg::S_PCH && limitHit) &&
            (!startCmd || shutoffIn)) begin
            next_state = pid_precharge_pkg::S_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= pid_precharge_pkg::S_IDLE;
            endCmdPrev <= 1'b0;
        end else begin
            state <= next_state;
            endCmdPrev <= endCmdActive;
        end
    end

    // Elapsed time in tenths of a second, fresh for every phase
    always_ff @(posedge core_clk) begin
        if (sys_rst || state != pid_precharge_pkg::S_PCH) begin
            tickCnt <= '0;
            elapsed <= '0;
        end else if (tickCnt == TICK_W'(TICK_CYCLES - 1)) begin
            tickCnt <= '0;
            if (elapsed != '1) begin
                elapsed <= elapsed + DATA_W'(1);
            end
        end else begin
            tickCnt <= tickCnt + TICK_W'(1);
        end
    end

    // Flags latch at the violation itself, also while decelerating
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            precharge_fault_flags <= 4'h0;
        end else if (state == pid_precharge_pkg::S_FAULT &&
            retryReq && retryOk) begin
            precharge_fault_flags <= 4'h0;
        end else if (state == pid_precharge_pkg::S_PCH && limitHit) begin
            precharge_fault_flags[controlMethod] <= 1'b1;
        end
    end

    assign second_next = second_function_select &&
        active(second_action_select);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            precharging_flag <= 1'b0;
            pidRun <= 1'b0;
            rampCmd <= 1'b0;
            decelCmd <= 1'b0;
            outputOff <= 1'b1;
            sleepActive <= 1'b0;
            precharge_fault <= 1'b0;
        end else begin
            precharging_flag <= next_state == pid_precharge_pkg::S_PCH;
            pidRun <= next_state == pid_precharge_pkg::S_PID;
            rampCmd <= next_state == pid_precharge_pkg::S_RAMP;
            decelCmd <= next_state == pid_precharge_pkg::S_DECEL;
            outputOff <= next_state == pid_precharge_pkg::S_IDLE ||
                next_state == pid_precharge_pkg::S_FAULT;
            sleepActive <= next_state == pid_precharge_pkg::S_SLEEP;
            precharge_fault <= next_state ==
                pid_precharge_pkg::S_FAULT;
        end
    end

    // Parameter set choice and integral estimate on return to normal set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            secondPrev <= 1'b0;
            useSecondSet <= 1'b0;
            integralPreload <= 1'b0;
            integralValue <= '0;
        end else begin
            secondPrev <= second_next;
            useSecondSet <= second_next;
            integralPreload <= secondPrev && !second_next;
            if (secondPrev && !second_next) begin
                integralValue <= outFreq - pTerm;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reverseAction <= 1'b0;
            deviationInput <= 1'b0;
        end else begin
            case (second_action_select)
                DATA_W'(`ACT_DEV_REV_A), DATA_W'(`ACT_DEV_REV_B): begin
                    reverseAction <= 1'b1;
                    deviationInput <= 1'b1;
                end
                DATA_W'(`ACT_DEV_FWD_A), DATA_W'(`ACT_DEV_FWD_B): begin
                    reverseAction <= 1'b0;
                    deviationInput <= 1'b1;
                end
                DATA_W'(`ACT_MSP_REV_A), DATA_W'(`ACT_MSP_REV_B): begin
                    reverseAction <= 1'b1;
                    deviationInput <= 1'b0;
                end
                default: begin
                    reverseAction <= 1'b0;
                    deviationInput <= 1'b0;
                end
            endcase
        end
    end

    // Register writes; limit writes not above the end value are dropped
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            precharge_end_level <= DATA_W'(`PCH_DISABLE);
            precharge_end_time <= DATA_W'(`PCH_DISABLE);
            upper_detect_level <= DATA_W'(`PCH_DISABLE);
            precharge_time_limit <= DATA_W'(`PCH_DISABLE);
            fault_behaviour_select <= DATA_W'(`FAULT_SEL_IMMEDIATE);
            retry_select <= DATA_W'(`RETRY_SEL_A);
            second_action_select <= DATA_W'(`PCH_DISABLE);
            ctrl <= DATA_W'(`CTRL_RESET);
        end else if (regWr) begin
            case (regAddr)
                `A_END_LEVEL: precharge_end_level <= regWdata;
                `A_END_TIME: precharge_end_time <= regWdata;
                `A_UPPER_LEVEL: begin
                    if (regWdata > precharge_end_level) begin
                        upper_detect_level <= regWdata;
                    end
                end
                `A_TIME_LIMIT: begin
                    if (regWdata > precharge_end_time) begin
                        precharge_time_limit <= regWdata;
                    end
                end
                `A_FAULT_SEL: fault_behaviour_select <= regWdata;
                `A_RETRY_SEL: retry_select <= regWdata;
                `A_SECOND_ACT: second_action_select <= regWdata;
                `A_CTRL: ctrl <= regWdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            case (regAddr)
                `A_END_LEVEL: regRdata <= precharge_end_level;
                `A_END_TIME: regRdata <= precharge_end_time;
                `A_UPPER_LEVEL: regRdata <= upper_detect_level;
                `A_TIME_LIMIT: regRdata <= precharge_time_limit;
                `A_FAULT_SEL: regRdata <= fault_behaviour_select;
                `A_RETRY_SEL: regRdata <= retry_select;
                `A_SECOND_ACT: regRdata <= second_action_select;
                `A_CTRL: regRdata <= ctrl;
                `A_STATUS: regRdata <= DATA_W'({precharge_fault_flags,
                    precharge_fault, state});
                `A_ELAPSED: regRdata <= elapsed;
                default: regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    end_level_a: assert property (
        state == pid_precharge_pkg::S_PCH && !limitHit && startCmd &&
        !shutoffIn && active(precharge_end_level) &&
        measured >= precharge_end_level |=> pidRun)
        else $error("end level did not start PID");
    end_cmd_a: assert property (
        state == pid_precharge_pkg::S_PCH && !limitHit && startCmd &&
        !shutoffIn && $rose(endCmdActive) |=> pidRun && !precharging_flag)
        else $error("end command edge ignored");
    skip_pch_a: assert property (
        state == pid_precharge_pkg::S_IDLE && startCmd && !shutoffIn &&
        pidSelect && endCmdActive |=> !precharging_flag && pidRun)
        else $error("pre-charge not skipped");
    limit_flag_a: assert property (
        state == pid_precharge_pkg::S_PCH && limitHit |=>
        precharge_fault_flags[$past(controlMethod)])
        else $error("fault flag not set");
    immediate_a: assert property (
        state == pid_precharge_pkg::S_PCH && limitHit &&
        fault_behaviour_select == DATA_W'(`FAULT_SEL_IMMEDIATE) |=>
        precharge_fault && outputOff)
        else $error("immediate fault missing");
    flags_hold_a: assert property (
        precharge_fault_flags != 4'h0 && !(retryReq && retryOk) |=>
        (precharge_fault_flags & $past(precharge_fault_flags)) ==
        $past(precharge_fault_flags))
        else $error("fault flags dropped");
    no_retry_a: assert property (
        precharge_fault && !retryOk |=> precharge_fault)
        else $error("retry with bad selection");
    sleep_gate_a: assert property (
        $rose(sleepActive) |-> $past(pidRun))
        else $error("sleep before pre-charge end");
    second_set_a: assert property (
        !active(second_action_select) |=> !useSecondSet)
        else $error("second set with 9999");
    preload_a: assert property (
        $fell(useSecondSet) |-> integralPreload &&
        integralValue == $past(outFreq) - $past(pTerm))
        else $error("integral not preloaded");

    pch_done_c: cover property (precharging_flag ##1 pidRun);
    decel_c: cover property (decelCmd ##[1:50] precharge_fault);
    retry_c: cover property (precharge_fault ##1 !precharge_fault);
    ramp_c: cover property (rampCmd ##1 precharging_flag);
endmodule

//--- tb/feedback_sensor_model.sv
// Model of the process feedback sensor and the external end-command line
// Assumes the bench sets the pump step and the end request
`timescale 1ns/1ps
module feedback_sensor_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic pumpOn,
    input wire logic [15:0] stepSize,
    input wire logic endReq,
    input wire logic precharging_flag,
    output logic [15:0] measured,
    output logic precharge_end_cmd
);
    // Level rises only while the drive runs the pump
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            measured <= 16'h0000;
        end else if (pumpOn) begin
            measured <= measured + stepSize;
        end
    end
    // Released only once pre-charge is over, so the next one re-arms
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            precharge_end_cmd <= 1'b0;
        end else if (endReq || !precharging_flag) begin
            precharge_end_cmd <= endReq;
        end
    end
endmodule

//--- tb/pid_precharge_sequencer_tb.sv
// Self-checking bench for the pre-charge sequencer
// Assumes the sensor model file; runs the design with a short tick
`timescale 1ns/1ps
`include "pid_precharge_regs.svh"
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin \
    failCount++; $display("unexpected at %0t got %h expected %h", \
    $time, got, exp); end end
`define WAITC(c, n) begin wc = 0; while (!(c) && wc < (n)) begin \
    @(negedge core_clk); wc++; end end
module pid_precharge_sequencer_tb;
    localparam int TICK = 16;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0, regRd = 1'b0, startCmd = 1'b0, pidSelect = 1'b1;
    logic higherPrioSrc = 1'b0, atSwitchFreq = 1'b0, shutoffIn = 1'b0;
    logic sleepReq = 1'b0, second_function_select = 1'b0;
    logic motorStopped = 1'b0, retryReq = 1'b0, endReq = 1'b0;
    logic [1:0] controlMethod = 2'h0;
    logic [15:0] outFreq = 16'h0000, pTerm = 16'h0000;
    logic [15:0] stepSize = 16'h0000;
    logic [15:0] regRdata, measured, integralValue, rd;
    logic precharge_end_cmd, precharging_flag, pidRun, rampCmd, decelCmd;
    logic outputOff, sleepActive, precharge_fault, useSecondSet;
    logic reverseAction, deviationInput, integralPreload, sawPch;
    logic [3:0] precharge_fault_flags;
    logic [15:0] codes [8] = '{`ACT_DEV_REV_A, `ACT_DEV_REV_B,
        `ACT_DEV_FWD_A, `ACT_DEV_FWD_B, `ACT_MSP_REV_A, `ACT_MSP_REV_B,
        `ACT_MSP_FWD_A, `ACT_MSP_FWD_B};
    logic [1:0] kinds [8] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
    int failCount = 0;
    int checksDone = 0;
    int cycles = 0;
    int wc;

    pid_precharge_sequencer #(.DATA_W(16), .TICK_CYCLES(TICK)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .startCmd(startCmd), .pidSelect(pidSelect),
        .higherPrioSrc(higherPrioSrc), .atSwitchFreq(atSwitchFreq),
        .shutoffIn(shutoffIn), .sleepReq(sleepReq),
        .precharge_end_cmd(precharge_end_cmd),
        .second_function_select(second_function_select),
        .measured(measured), .controlMethod(controlMethod),
        .motorStopped(motorStopped), .retryReq(retryReq),
        .outFreq(outFreq), .pTerm(pTerm),
        .precharging_flag(precharging_flag), .pidRun(pidRun),
        .rampCmd(rampCmd), .decelCmd(decelCmd), .outputOff(outputOff),
        .sleepActive(sleepActive),
        .precharge_fault_flags(precharge_fault_flags),
        .precharge_fault(precharge_fault), .useSecondSet(useSecondSet),
        .reverseAction(reverseAction), .deviationInput(deviationInput),
        .integralPreload(integralPreload), .integralValue(integralValue));

    feedback_sensor_model i_sensor (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .pumpOn(precharging_flag | pidRun), .stepSize(stepSize),
        .endReq(endReq), .precharging_flag(precharging_flag),
        .measured(measured), .precharge_end_cmd(precharge_end_cmd));

    always #10 core_clk = ~core_clk;

    always @(negedge core_clk) begin
        if (precharging_flag === 1'b1) begin
            sawPch = 1'b1;
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            finalReport();
        end
    end

    task automatic finalReport();
        if (failCount == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [3:0] a);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        rd = regRdata;
    endtask

    task automatic doReset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        {startCmd, endReq, shutoffIn, sleepReq} <= 4'h0;
        {higherPrioSrc, atSwitchFreq, motorStopped, pidSelect} <= 4'h1;
        stepSize <= 16'h0000;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask

    task automatic startRun(input logic [15:0] ctrl);
        regWrite(`A_CTRL, ctrl);
        @(posedge core_clk);
        startCmd <= 1'b1;
    endtask

    task automatic pulseRetry();
        @(posedge core_clk);
        retryReq <= 1'b1;
        @(posedge core_clk);
        retryReq <= 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic testTimeEndShutoff();
        doReset();
        regWrite(`A_END_TIME, 16'h0002);
        startRun(16'h0003);
        `WAITC(precharging_flag === 1'b1, 4)
        `WAITC(pidRun === 1'b1, 100)
        `CHECK(wc >= 2 * TICK - 2 && wc <= 3 * TICK + 2, 1'b1)
        @(posedge core_clk);
        shutoffIn <= 1'b1;
        `WAITC(outputOff === 1'b1, 3)
        @(posedge core_clk);
        shutoffIn <= 1'b0;
        `WAITC(precharging_flag === 1'b1, 4)
        `CHECK(precharging_flag, 1'b1)
        regRead(`A_ELAPSED);
        `CHECK(rd < 16'h0002, 1'b1)
        @(posedge core_clk);
        endReq <= 1'b1;
        `WAITC(pidRun === 1'b1, 4)
        `CHECK(pidRun, 1'b1)
        @(posedge core_clk);
        shutoffIn <= 1'b1;
        `WAITC(outputOff === 1'b1, 3)
        sawPch = 1'b0;
        @(posedge core_clk);
        shutoffIn <= 1'b0;
        `WAITC(pidRun === 1'b1, 4)
        `CHECK({pidRun, sawPch}, 2'b10)
    endtask

    task automatic testLevelEnd();
        doReset();
        regWrite(`A_END_LEVEL, 16'h0064);
        regWrite(`A_END_TIME, 16'h0009);
        startRun(16'h0001);
        sleepReq <= 1'b1;
        stepSize <= 16'h0005;
        `WAITC(pidRun === 1'b1, 60)
        `CHECK(measured >= 16'h0064, 1'b1)
        `CHECK(measured <= 16'h0073, 1'b1)
        `CHECK(sleepActive, 1'b0)
        `WAITC(sleepActive === 1'b1, 3)
        `CHECK(sleepActive, 1'b1)
    endtask

    task automatic testSkipStart();
        doReset();
        endReq <= 1'b1;
        repeat (2) @(posedge core_clk);
        sawPch = 1'b0;
        startRun(16'h0003);
        `WAITC(pidRun === 1'b1, 4)
        `CHECK({pidRun, sawPch}, 2'b10)
    endtask

    task automatic testRamp();
        doReset();
        {higherPrioSrc, pidSelect} <= 2'h2;
        startRun(16'h0001);
        repeat (3) @(negedge core_clk);
        `CHECK({rampCmd, precharging_flag}, 2'b00)
        @(posedge core_clk);
        {higherPrioSrc, pidSelect} <= 2'h1;
        `WAITC(rampCmd === 1'b1, 3)
        `CHECK({rampCmd, precharging_flag}, 2'b10)
        @(posedge core_clk);
        atSwitchFreq <= 1'b1;
        `WAITC(precharging_flag === 1'b1, 3)
        `CHECK({rampCmd, precharging_flag}, 2'b01)
    endtask

    task automatic testTimeFault();
        doReset();
        regWrite(`A_END_TIME, 16'h0001);
        regWrite(`A_TIME_LIMIT, 16'h0003);
        regWrite(`A_TIME_LIMIT, 16'h0000);
        regWrite(`A_UPPER_LEVEL, 16'h0005);
        regWrite(`A_END_TIME, `PCH_DISABLE);
        regRead(`A_TIME_LIMIT);
        `CHECK(rd, 16'h0003)
        regRead(`A_UPPER_LEVEL);
        `CHECK(rd, `PCH_DISABLE)
        regRead(4'hF);
        `CHECK(rd, 16'h0000)
        startRun(16'h0001);
        controlMethod <= 2'h2;
        `WAITC(precharging_flag === 1'b1, 4)
        `WAITC(precharge_fault === 1'b1, 80)
        `CHECK(wc >= 2 * TICK && wc <= 4 * TICK + 2, 1'b1)
        `CHECK(precharge_fault_flags, 4'h4)
        `CHECK({outputOff, decelCmd}, 2'b10)
        @(posedge core_clk);
        controlMethod <= 2'h1;
        regWrite(`A_RETRY_SEL, 16'h0001);
        pulseRetry();
        `CHECK(precharge_fault_flags, 4'h4)
        regWrite(`A_RETRY_SEL, `RETRY_SEL_B);
        pulseRetry();
        `CHECK(precharge_fault_flags, 4'h0)
    endtask

    task automatic testDecelFault();
        doReset();
        regWrite(`A_FAULT_SEL, 16'h0001);
        regWrite(`A_UPPER_LEVEL, 16'h2710);
        startRun(16'h0001);
        controlMethod <= 2'h3;
        stepSize <= 16'h0400;
        `WAITC(decelCmd === 1'b1, 30)
        `CHECK(measured > 16'h2710, 1'b1)
        `CHECK(precharge_fault_flags, 4'h8)
        repeat (5) @(negedge core_clk);
        `CHECK({precharge_fault, decelCmd}, 2'b01)
        @(posedge core_clk);
        motorStopped <= 1'b1;
        `WAITC(precharge_fault === 1'b1, 4)
        `CHECK({precharge_fault, precharge_fault_flags}, 5'h18)
        doReset();
        @(negedge core_clk);
        `CHECK(precharge_fault_flags, 4'h0)
    endtask

    task automatic testSecondSet();
        doReset();
        endReq <= 1'b1;
        outFreq <= 16'h0300;
        pTerm <= 16'h0120;
        startRun(16'h0003);
        for (int i = 0; i < 8; i++) begin
            regWrite(`A_SECOND_ACT, codes[i]);
            second_function_select <= 1'b1;
            repeat (2) @(negedge core_clk);
            `CHECK(useSecondSet, 1'b1)
            `CHECK({reverseAction, deviationInput}, kinds[i])
            @(posedge core_clk);
            second_function_select <= 1'b0;
            `WAITC(integralPreload === 1'b1, 3)
            `CHECK({integralPreload, integralValue}, 17'h101E0)
        end
        regWrite(`A_SECOND_ACT, `PCH_DISABLE);
        second_function_select <= 1'b1;
        repeat (2) @(negedge core_clk);
        `CHECK(useSecondSet, 1'b0)
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        testTimeEndShutoff();
        testLevelEnd();
        testSkipStart();
        testRamp();
        testTimeFault();
        testDecelFault();
        testSecondSet();
        finalReport();
    end
endmodule
